// File: pmis_pkg.sv
// pmis_pkg: constants, register map and carrier types of the power meter bus slave
// assumes a 250 MHz core clock and tri-level strap codes from an outside pad detector
package pmis_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 250;
  localparam int BUS_TIMEOUT_MS  = 30;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int AZ_TIME_US      = 1500;
  localparam int AZ_CYC          = AZ_TIME_US * CLK_MHZ;
  localparam int DATA_SETUP_NS   = 100;
  localparam int SU_CYC          = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int TO_W            = 23;
  localparam int AZ_W            = 19;
  localparam int SU_W            = 6;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // address and checksum
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE  = 7'h60;
  localparam int         STRAP_W2   = 9;
  localparam int         STRAP_W1   = 3;
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_FLT  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'h00;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_TEMP  = 8'h07;
  localparam logic [7:0] CMD_AZ    = 8'h0f;
  localparam logic [7:0] CMD_CFG   = 8'h22;
  localparam logic [7:0] CMD_LOWPASS_COMPENSATION  = 8'h23;
  localparam logic [7:0] CMD_PA    = 8'h24;
  localparam logic [7:0] CMD_VGAIN = 8'h2a;
  localparam logic [7:0] CMD_IGAIN = 8'h2b;
  localparam logic [7:0] CMD_Q     = 8'h32;
  localparam logic [7:0] CMD_SUM   = 8'h34;
  localparam logic [7:0] CMD_S     = 8'h3a;
  localparam logic [7:0] CMD_PF    = 8'h3c;
  localparam logic [7:0] CMD_P     = 8'h42;
  localparam logic [7:0] CMD_VOLTAGE_RMS_RESULT  = 8'h4a;
  localparam logic [7:0] CMD_CURRENT_RMS_RESULT  = 8'h52;
  localparam logic [7:0] CMD_AVERAGE_POWER_RESULT  = 8'h5a;
  localparam logic [7:0] CMD_POFFS = 8'h84;
  localparam logic [7:0] CMD_PGAIN = 8'h8c;
  localparam logic [7:0] CMD_IOFFS = 8'hac;
  localparam logic [7:0] CMD_IK    = 8'hb2;
  localparam logic [7:0] CMD_IGV   = 8'hba;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          PEC_BIT   = 3;
  localparam logic [15:0] CFG_RESET = 16'hf102;
  localparam logic [15:0] COEF_RST  = 16'h0000;
  localparam logic [2:0]  LEN_NARROW = 3'h2;
  localparam logic [2:0]  LEN_WIDE   = 3'h3;
  localparam logic [2:0]  LEN_AZ     = 3'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] processing_config;
    logic [15:0] lowpass_compensation;
    logic [15:0] phase_angle_coeff;
    logic [15:0] voltage_gain_coeff;
    logic [15:0] current_gain_coeff;
    logic [15:0] frames_per_cycle;
    logic [15:0] active_power_offset;
    logic [15:0] active_power_gain;
    logic [15:0] current_rms_offset;
    logic [15:0] current_rms_correction;
    logic [15:0] current_rms_volt_gain;
  } pmis_coef_t;

  typedef struct packed {
    logic [15:0] die_temperature_sample;
    logic [23:0] active_power_result;
    logic [23:0] reactive_power_result;
    logic [23:0] apparent_power_result;
    logic [23:0] average_power_result;
    logic [23:0] voltage_rms_result;
    logic [23:0] current_rms_result;
    logic [23:0] power_factor_result;
  } pmis_meas_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RXB   = 3'b001,
    ST_ACK   = 3'b011,
    ST_WAIT  = 3'b010,
    ST_TXB   = 3'b110,
    ST_TXACK = 3'b111,
    ST_IGN   = 3'b101
  } pmis_st_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b11
  } pmis_ph_t;

endpackage : pmis_pkg

// File: pmis_slave.sv
// pmis_slave: two-wire register slave of a single-phase power meter
// assumes open-drain pads outside, measurement results and busy flag on CLK
//
// Behaviour
// R1: reset pin is held low at least 1us; device stays reset while low.
// R2: on reset release every register returns to its default value.
// R3: analog supply fail holds reset; on recovery registers return to defaults.
// R4: master rewrites all configuration and calibration after every reset.
// R5: bytes are 8 bits, msb first, each followed by ack or nack.
// R6: master keeps the serial clock at or below 400 kHz.
// R7: device may hold the clock low while it prepares data.
// R8: clock low for 30 ms resets the bus controller and frees both lines.
// R9: three strap pins sampled after every reset form the 7-bit address.
// R10: address is 60h plus base-3 strap digits, low 0, float 1, high 2.
// R11: with the checksum enable bit set, sender appends a checksum byte.
// R12: checksum is crc-8, poly 07h, init zero, over address and all bytes.
// R13: first byte after the address is the register command code.
// R14: two data bytes normally; three for power, rms and factor reads.
// R15: read of a result being computed stretches clock until done or timeout.
// R16: only the strapped address answers; no broadcast or alert response.
// R17: any write to the autozero command starts a 1.5 ms converter reset.
// R18: master issues autozero only during initialisation.
// R19: results stay readable while measurement keeps running.
// R20: power factor is 24 bits, lsb 2^-16, command 3ch.
// R21: reset sets the four reset-status bits to 1111; master clears them.
// R22: writes to read-only results change nothing but still complete.
`timescale 1ns/100ps
`default_nettype none

module pmis_slave #(
  parameter int TIMEOUT_CYC = pmis_pkg::BUS_TIMEOUT_CYC,
  parameter int AZ_CYCLES   = pmis_pkg::AZ_CYC
) (
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 SCL_I,
  output var  logic                 SCL_O,
  output var  logic                 SCL_OE,
  input  wire logic                 SDA_I,
  output var  logic                 SDA_O,
  output var  logic                 SDA_OE,
  input  wire logic [1:0]           ADDR_STRAP_HI,
  input  wire logic [1:0]           ADDR_STRAP_MID,
  input  wire logic [1:0]           ADDR_STRAP_LO,
  input  wire logic                 ANALOG_SUPPLY_FAIL,
  input  wire logic                 CALC_BUSY,
  input  wire pmis_pkg::pmis_meas_t MEAS,
  output var  pmis_pkg::pmis_coef_t COEF,
  output var  logic                 AUTOZERO_BUSY
);
  import pmis_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << TO_W)) begin : g_bad_to
    $error("TIMEOUT_CYC out of range");
  end
  if (AZ_CYCLES < 1 || AZ_CYCLES >= (1 << AZ_W)) begin : g_bad_az
    $error("AZ_CYCLES out of range");
  end

  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);
  localparam logic [AZ_W-1:0] AZ_LOAD = AZ_W'(AZ_CYCLES - 1);
  localparam logic [SU_W-1:0] SU_LAST = SU_W'(SU_CYC - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            scl_s1;
    logic            scl_s2;
    logic            scl_d;
    logic            sda_s1;
    logic            sda_s2;
    logic            sda_d;
    logic            pf_s1;
    logic            pf_s2;
    logic [5:0]      strap_s1;
    logic [5:0]      strap_s2;
    logic [1:0]      strap_cnt;
    logic            strap_done;
    logic [6:0]      dev_addr;
    pmis_st_t        st;
    pmis_ph_t        ph;
    logic [3:0]      bitcnt;
    logic [2:0]      bytecnt;
    logic [7:0]      shreg;
    logic            rw;
    logic            mack;
    logic [7:0]      cmd;
    logic [15:0]     wdata;
    logic [23:0]     rdata;
    logic [7:0]      crc;
    logic            sda_oe;
    logic            scl_oe;
    logic            line_lvl;
    logic [SU_W-1:0] su_cnt;
    logic [TO_W-1:0] to_cnt;
    logic            az_busy;
    logic [AZ_W-1:0] az_cnt;
    pmis_coef_t      coef;
  } pmis_state_t;

  localparam pmis_coef_t COEF_RESET = '{
    processing_config: CFG_RESET, // R21
    default:           COEF_RST
  };
  localparam pmis_state_t ST_RESET = '{
    st:      ST_IDLE,
    ph:      PH_ADDR,
    coef:    COEF_RESET,
    default: '0
  };

  pmis_state_t r;
  pmis_state_t n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = c;
    for (int i = 7; i >= 0; i--) begin
      if (v[7] ^ d[i]) begin
        v = {v[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        v = {v[6:0], 1'b0};
      end
    end
    return v;
  endfunction : crc8

  function automatic int strap_digit(input logic [1:0] s);
    int d;
    d = 1;
    if (s == STRAP_LOW) begin
      d = 0;
    end else if (s == STRAP_HIGH) begin
      d = 2;
    end
    return d;
  endfunction : strap_digit

  function automatic logic [6:0] strap_addr(input logic [5:0] s);
    int sum;
    sum = int'(ADDR_BASE) + STRAP_W2 * strap_digit(s[5:4])
        + STRAP_W1 * strap_digit(s[3:2]) + strap_digit(s[1:0]);
    return 7'(sum);
  endfunction : strap_addr

  function automatic logic is_result(input logic [7:0] c);
    return c == CMD_P || c == CMD_Q || c == CMD_S || c == CMD_AVERAGE_POWER_RESULT
        || c == CMD_VOLTAGE_RMS_RESULT || c == CMD_CURRENT_RMS_RESULT || c == CMD_PF;
  endfunction : is_result

  function automatic logic [2:0] rd_len(input logic [7:0] c);
    return is_result(c) ? LEN_WIDE : LEN_NARROW;
  endfunction : rd_len

  function automatic logic [2:0] wr_len(input logic [7:0] c);
    return (c == CMD_AZ) ? LEN_AZ : LEN_NARROW;
  endfunction : wr_len

  function automatic logic [23:0] rd_value(input logic [7:0] c, input pmis_coef_t k,
                                           input pmis_meas_t m);
    logic [23:0] v;
    v = '0;
    unique case (c)
      CMD_TEMP:  v = {8'h00, m.die_temperature_sample};
      CMD_CFG:   v = {8'h00, k.processing_config};
      CMD_LOWPASS_COMPENSATION:  v = {8'h00, k.lowpass_compensation};
      CMD_PA:    v = {8'h00, k.phase_angle_coeff};
      CMD_VGAIN: v = {8'h00, k.voltage_gain_coeff};
      CMD_IGAIN: v = {8'h00, k.current_gain_coeff};
      CMD_SUM:   v = {8'h00, k.frames_per_cycle};
      CMD_POFFS: v = {8'h00, k.active_power_offset};
      CMD_PGAIN: v = {8'h00, k.active_power_gain};
      CMD_IOFFS: v = {8'h00, k.current_rms_offset};
      CMD_IK:    v = {8'h00, k.current_rms_correction};
      CMD_IGV:   v = {8'h00, k.current_rms_volt_gain};
      CMD_Q:     v = m.reactive_power_result;
      CMD_S:     v = m.apparent_power_result;
      CMD_PF:    v = m.power_factor_result; // R20
      CMD_P:     v = m.active_power_result;
      CMD_VOLTAGE_RMS_RESULT:  v = m.voltage_rms_result;
      CMD_CURRENT_RMS_RESULT:  v = m.current_rms_result;
      CMD_AVERAGE_POWER_RESULT:  v = m.average_power_result;
      default:   v = '0;
    endcase
    return v;
  endfunction : rd_value

  // result codes fall to default: no store
  function automatic pmis_coef_t coef_write(input pmis_coef_t k, input logic [7:0] c,
                                            input logic [15:0] d);
    pmis_coef_t v;
    v = k;
    unique case (c)
      CMD_CFG:   v.processing_config      = d;
      CMD_LOWPASS_COMPENSATION:  v.lowpass_compensation   = d;
      CMD_PA:    v.phase_angle_coeff      = d;
      CMD_VGAIN: v.voltage_gain_coeff     = d;
      CMD_IGAIN: v.current_gain_coeff     = d;
      CMD_SUM:   v.frames_per_cycle       = d;
      CMD_POFFS: v.active_power_offset    = d;
      CMD_PGAIN: v.active_power_gain      = d;
      CMD_IOFFS: v.current_rms_offset     = d;
      CMD_IK:    v.current_rms_correction = d;
      CMD_IGV:   v.current_rms_volt_gain  = d;
      default:   v = k; // R22
    endcase
    return v;
  endfunction : coef_write

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        pec;
    logic        ack;
    logic        nack;
    logic        commit;
    logic        do_load;
    logic [7:0]  ld_byte;
    logic [7:0]  b;
    logic [2:0]  idx;
    logic [15:0] wd_new;
    logic [23:0] val;
    rise    = r.scl_s2 & ~r.scl_d;
    fall    = ~r.scl_s2 & r.scl_d;
    start   = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    stop    = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    pec     = r.coef.processing_config[PEC_BIT];
    ack     = 1'b0;
    nack    = 1'b0;
    commit  = 1'b0;
    do_load = 1'b0;
    ld_byte = '0;
    b       = r.shreg;
    idx     = r.bytecnt + 3'h1;
    wd_new  = (r.bytecnt == '0) ? {8'h00, b} : {b, r.wdata[7:0]};
    val     = '0;
    n       = r;

    n.scl_s1   = SCL_I;
    n.scl_s2   = r.scl_s1;
    n.scl_d    = r.scl_s2;
    n.sda_s1   = SDA_I;
    n.sda_s2   = r.sda_s1;
    n.sda_d    = r.sda_s2;
    n.pf_s1    = ANALOG_SUPPLY_FAIL;
    n.pf_s2    = r.pf_s1;
    n.strap_s1 = {ADDR_STRAP_HI, ADDR_STRAP_MID, ADDR_STRAP_LO};
    n.strap_s2 = r.strap_s1;

    if (!r.strap_done) begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == STRAP_SETTLE) begin
        n.dev_addr   = strap_addr(r.strap_s2); // R9 R10
        n.strap_done = 1'b1;
      end
    end

    if (r.az_busy) begin
      if (r.az_cnt == '0) begin
        n.az_busy = 1'b0;
      end else begin
        n.az_cnt = r.az_cnt - 1'b1; // R17
      end
    end

    if (r.scl_s2) begin
      n.to_cnt = '0;
    end else if (r.to_cnt != TO_LAST) begin
      n.to_cnt = r.to_cnt + 1'b1;
    end

    if (start) begin
      n.st     = ST_RXB;
      n.ph     = PH_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      if (r.st == ST_IDLE) begin
        n.crc = CRC_INIT; // R12
      end
    end else if (stop) begin
      n.st     = ST_IDLE;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end else begin
      unique case (r.st)
        ST_IDLE, ST_IGN: begin
          n.sda_oe = 1'b0;
        end
        ST_RXB: begin
          if (rise) begin
            n.shreg  = {r.shreg[6:0], r.sda_s2}; // R5
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (fall && r.bitcnt == 4'h8) begin
            unique case (r.ph)
              PH_ADDR: begin
                if (r.strap_done && b[7:1] == r.dev_addr) begin // R16
                  ack   = 1'b1;
                  n.rw  = b[0];
                  n.crc = crc8(r.crc, b);
                  if (!b[0]) begin
                    n.ph = PH_CMD;
                  end
                end else begin
                  nack = 1'b1;
                end
              end
              PH_CMD: begin
                ack       = 1'b1;
                n.cmd     = b; // R13
                n.crc     = crc8(r.crc, b);
                n.ph      = PH_DATA;
                n.bytecnt = '0;
              end
              default: begin
                if (r.bytecnt < wr_len(r.cmd)) begin // R14
                  ack       = 1'b1;
                  n.wdata   = wd_new;
                  n.crc     = crc8(r.crc, b);
                  n.bytecnt = idx;
                  commit    = (idx == wr_len(r.cmd)) && !pec;
                end else if (r.bytecnt == wr_len(r.cmd) && pec && b == r.crc) begin // R11
                  ack       = 1'b1;
                  commit    = 1'b1;
                  wd_new    = r.wdata;
                  n.bytecnt = idx;
                end else begin
                  nack = 1'b1;
                end
              end
            endcase
            if (ack) begin
              n.sda_oe = 1'b1;
              n.st     = ST_ACK;
            end
            if (nack) begin
              n.st = ST_IGN;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.bitcnt = '0;
            if (r.rw) begin
              n.st     = ST_WAIT;
              n.scl_oe = 1'b1; // R7
            end else begin
              n.st = ST_RXB;
            end
          end
        end
        ST_WAIT: begin
          if (!(CALC_BUSY && is_result(r.cmd))) begin // R15
            val       = rd_value(r.cmd, r.coef, MEAS); // R19
            n.rdata   = val;
            n.bytecnt = '0;
            n.su_cnt  = '0;
            do_load   = 1'b1;
            ld_byte   = val[7:0];
          end
        end
        ST_TXB: begin
          if (r.scl_oe) begin
            n.su_cnt = r.su_cnt + 1'b1;
            if (r.su_cnt == SU_LAST) begin
              n.scl_oe = 1'b0;
            end
          end else if (rise) begin
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (fall) begin
            if (r.bitcnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st     = ST_TXACK;
            end else begin
              n.shreg  = {r.shreg[6:0], 1'b0};
              n.sda_oe = ~r.shreg[6]; // R5
            end
          end
        end
        ST_TXACK: begin
          if (rise) begin
            n.mack = ~r.sda_s2;
          end else if (fall) begin
            if (r.mack && idx < rd_len(r.cmd)) begin // R14
              do_load   = 1'b1;
              ld_byte   = r.rdata[8*idx +: 8];
              n.bytecnt = idx;
            end else if (r.mack && idx == rd_len(r.cmd) && pec) begin // R11
              do_load   = 1'b1;
              ld_byte   = r.crc;
              n.bytecnt = idx;
            end else begin
              n.st = ST_IGN;
            end
          end
        end
        default: begin
          n.st     = ST_IDLE;
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b0;
        end
      endcase
    end

    if (do_load) begin
      n.shreg  = ld_byte;
      n.sda_oe = ~ld_byte[7];
      n.crc    = crc8(r.crc, ld_byte); // R12
      n.bitcnt = '0;
      n.st     = ST_TXB;
    end

    if (commit) begin
      if (r.cmd == CMD_AZ) begin
        n.az_busy = 1'b1; // R17
        n.az_cnt  = AZ_LOAD;
      end else begin
        n.coef = coef_write(r.coef, r.cmd, wd_new); // R22
      end
    end

    if (!r.scl_s2 && r.to_cnt == TO_LAST) begin
      n.st     = ST_IDLE; // R8
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end

    if (r.pf_s2) begin
      n          = ST_RESET; // R3
      n.pf_s1    = ANALOG_SUPPLY_FAIL;
      n.pf_s2    = r.pf_s1;
      n.scl_s1   = SCL_I;
      n.scl_s2   = r.scl_s1;
      n.sda_s1   = SDA_I;
      n.sda_s2   = r.sda_s1;
      n.strap_s1 = {ADDR_STRAP_HI, ADDR_STRAP_MID, ADDR_STRAP_LO};
      n.strap_s2 = r.strap_s1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r <= ST_RESET; // R2
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    SCL_O         = r.line_lvl;
    SCL_OE        = r.scl_oe;
    SDA_O         = r.line_lvl;
    SDA_OE        = r.sda_oe;
    COEF          = r.coef;
    AUTOZERO_BUSY = r.az_busy;
  end

endmodule : pmis_slave

`default_nettype wire

// File: pmis_slave_chk.sv
// pmis_slave_chk: port assertions of the power meter bus slave
// assumes bind onto pmis_slave with its parameters
`timescale 1ns/100ps
`default_nettype none
module pmis_slave_chk #(
  parameter int TIMEOUT_CYC = 2000,
  parameter int AZ_CYCLES   = 100
) (
  input wire logic                 CLK,
  input wire logic                 RESETN,
  input wire logic                 SCL_I,
  input wire logic                 SCL_O,
  input wire logic                 SCL_OE,
  input wire logic                 SDA_O,
  input wire logic                 SDA_OE,
  input wire logic                 ANALOG_SUPPLY_FAIL,
  input wire logic                 CALC_BUSY,
  input wire pmis_pkg::pmis_coef_t COEF,
  input wire logic                 AUTOZERO_BUSY
);
  import pmis_pkg::*;
  int low_r;
  int az_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      low_r <= 0;
      az_r  <= 0;
    end else begin
      low_r <= SCL_I ? 0 : low_r + 1;
      az_r  <= AUTOZERO_BUSY ? az_r + 1 : 0;
    end
  end
  sequence s_ready_read;
    $rose(SCL_OE) ##0 !CALC_BUSY [*8];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !RESETN |-> !SCL_OE && !SDA_OE)
    else $error("bus lines driven in reset");
  a_cfg_default: assert property ($rose(RESETN) |-> COEF.processing_config == CFG_RESET)
    else $error("config not at default after reset");
  a_supply_hold: assert property (ANALOG_SUPPLY_FAIL [*6] |-> COEF[159:0] == '0
    && COEF.processing_config == CFG_RESET && !SDA_OE && !AUTOZERO_BUSY)
    else $error("state kept during supply fail");
  a_az_length: assert property ($fell(AUTOZERO_BUSY) |-> az_r == AZ_CYCLES)
    else $error("autozero busy length wrong");
  a_timeout_free: assert property (low_r > TIMEOUT_CYC + 1 |-> !SCL_OE && !SDA_OE)
    else $error("lines held after clock low timeout");
  a_sda_drive: assert property ($rose(SDA_OE) |-> !SCL_I)
    else $error("data driven while clock high");
  a_drain_low: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
    else $error("pad output value not low");
  a_stretch_end: assert property (s_ready_read |-> ##[1:30] !SCL_OE)
    else $error("stretch not released");
  a_busy_hold: assert property (CALC_BUSY && SCL_OE && low_r < TIMEOUT_CYC |=> SCL_OE)
    else $error("stretch dropped while busy");
endmodule : pmis_slave_chk
bind pmis_slave pmis_slave_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .AZ_CYCLES(AZ_CYCLES)) chk_u (.*);
`default_nettype wire

// File: pmis_mst_mdl.sv
// pmis_mst_mdl: bus master model, pulls lines low only
// assumes pull-ups outside; a 125 ns link clock period
`timescale 1ns/100ps
`default_nettype none
module pmis_mst_mdl (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic scl_lo,
  output var  logic sda_lo
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  task automatic hq();
    #31.25;
  endtask : hq
  // release clock and wait out a stretch of up to 80 us
  task automatic up();
    scl_lo = 1'b0;
    for (int n = 0; n < 20000 && !scl; n++) #4;
    hq();
  endtask : up
  task automatic bit_io(input logic b, output logic r);
    sda_lo = !b;
    hq();
    up();
    r = sda;
    hq();
    scl_lo = 1'b1;
    hq();
  endtask : bit_io
  task automatic start();
    sda_lo = 1'b0;
    hq();
    up();
    sda_lo = 1'b1;
    hq();
    scl_lo = 1'b1;
    hq();
  endtask : start
  task automatic stop();
    sda_lo = 1'b1;
    hq();
    up();
    sda_lo = 1'b0;
    hq();
  endtask : stop
  task automatic xfer(input logic [7:0] w, input logic k, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(k, a);
  endtask : xfer
endmodule : pmis_mst_mdl
`default_nettype wire

// File: pmis_slave_tb_top.sv
// pmis_slave_tb_top: register tests of the bus slave
// assumes pmis_mst_mdl as master, pull-ups on both lines
`timescale 1ns/100ps
`default_nettype none
module pmis_slave_tb_top;
  import pmis_pkg::*;
  logic       clk, rstn, fail, busy, scl_oe, sda_oe, scl_o, sda_o, az, pec;
  logic [1:0] s_hi, s_mid, s_lo;
  logic [6:0] dev;
  logic [7:0] crc;
  logic [23:0] v;
  logic [6:0] alien [3] = '{7'h60, 7'h00, 7'h0c};
  pmis_meas_t meas;
  pmis_coef_t coef;
  wire logic  scl_lo, sda_lo;
  wire logic  scl = !(scl_lo || scl_oe);
  wire logic  sda = !(sda_lo || sda_oe);
  int         err_total, comparisons, cyc;
  pmis_slave #(.TIMEOUT_CYC(2000), .AZ_CYCLES(100)) dut_u (
    .CLK(clk), .RESETN(rstn), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_STRAP_HI(s_hi),
    .ADDR_STRAP_MID(s_mid), .ADDR_STRAP_LO(s_lo), .ANALOG_SUPPLY_FAIL(fail),
    .CALC_BUSY(busy), .MEAS(meas), .COEF(coef), .AUTOZERO_BUSY(az));
  pmis_mst_mdl mst_u (.scl(scl), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c ^= d;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic tx(input logic [7:0] b, input logic ea);
    logic [7:0] r;
    logic a;
    mst_u.xfer(b, 1'b1, r, a);
    crc = crc8(crc, b);
    chk(24'(a), 24'(ea));
  endtask : tx
  task automatic rx(input logic k, output logic [7:0] r);
    logic a;
    mst_u.xfer(8'hff, k, r, a);
    crc = crc8(crc, r);
  endtask : rx
  task automatic wr(input logic [7:0] c, input int n, input logic [23:0] d,
                    input logic [7:0] flip = 8'h00);
    crc = 8'h00;
    mst_u.start();
    tx({dev, 1'b0}, 1'b0);
    tx(c, 1'b0);
    for (int i = 0; i < n; i++) tx(d[8*i +: 8], 1'b0);
    if (pec) tx(crc ^ flip, flip != 8'h00);
    mst_u.stop();
  endtask : wr
  task automatic rd(input logic [7:0] c, input int n, output logic [23:0] d);
    logic [7:0] r, e;
    crc = 8'h00;
    d = '0;
    mst_u.start();
    tx({dev, 1'b0}, 1'b0);
    tx(c, 1'b0);
    mst_u.start();
    tx({dev, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      rx(i == n - 1 && !pec, r);
      d[8*i +: 8] = r;
    end
    e = crc;
    if (pec) rx(1'b1, r);
    if (pec) chk(24'(r), 24'(e));
    mst_u.stop();
  endtask : rd
  initial begin
    {rstn, fail, busy, pec} = 4'h0;
    {s_hi, s_mid, s_lo} = 6'b01_10_00;
    meas = {16'h0123, 24'h456789, 24'h89abcd, 24'h13579b, 24'h2468ac, 24'h314159,
            24'h271828, 24'h00c0de};
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (20) @(negedge clk);
    dev = 7'h60 + 7'd9 + 7'd6;
    rd(CMD_CFG, 2, v);
    chk(v, 24'h00f102);
    wr(CMD_VGAIN, 2, 24'h00beef);
    chk(24'(coef.voltage_gain_coeff), 24'h00beef);
    rd(CMD_VGAIN, 2, v);
    chk(v, 24'h00beef);
    wr(CMD_P, 2, 24'h001111);
    chk(24'(coef[159:0] == 160'hbeef << 112), 24'h1);
    rd(CMD_P, 3, v);
    chk(v, 24'h456789);
    rd(CMD_PF, 3, v);
    chk(v, 24'h00c0de);
    rd(CMD_TEMP, 2, v);
    chk(v, 24'h000123);
    foreach (alien[i]) begin
      mst_u.start();
      tx({alien[i], 1'b0}, 1'b1);
      mst_u.stop();
    end
    wr(CMD_AZ, 1, 24'h00005a);
    chk(24'(az), 24'h1);
    repeat (110) @(negedge clk);
    chk(24'(az), 24'h0);
    busy = 1'b1;
    fork
      rd(CMD_VOLTAGE_RMS_RESULT, 3, v);
      begin
        wait (scl_oe);
        repeat (300) @(negedge clk);
        chk(24'(scl_oe), 24'h1);
        busy = 1'b0;
      end
    join
    chk(v, 24'h314159);
    @(negedge clk) busy = 1'b1;
    rd(CMD_PF, 3, v);
    @(negedge clk) busy = 1'b0;
    chk(v, 24'hffffff);
    rd(CMD_VGAIN, 2, v);
    chk(v, 24'h00beef);
    wr(CMD_CFG, 2, 24'h00000a);
    chk(24'(coef.processing_config), 24'h00000a);
    pec = 1'b1;
    wr(CMD_IK, 2, 24'h00c3a5);
    rd(CMD_IK, 2, v);
    chk(v, 24'h00c3a5);
    wr(CMD_IK, 2, 24'h001234, 8'h01);
    chk(24'(coef.current_rms_correction), 24'h00c3a5);
    fail = 1'b1;
    {s_hi, s_mid, s_lo} = 6'b10_10_10;
    repeat (10) @(negedge clk);
    chk(24'(coef.processing_config), 24'(CFG_RESET));
    fail = 1'b0;
    pec = 1'b0;
    repeat (30) @(negedge clk);
    dev = 7'h7a;
    rd(CMD_CFG, 2, v);
    chk(v, 24'h00f102);
    give_verdict();
  end
endmodule : pmis_slave_tb_top
`default_nettype wire
